// *** design/ghb_device.sv ***
module ghb_device (
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_nrst,
	input  wire logic                          i_wait_mode,
	ghb_if.dev                                 bus,
	output logic                               o_wr_valid,
	output logic [ghb_pkg::ADDR_W-1:0]         o_wr_addr,
	output logic [ghb_pkg::DATA_W-1:0]         o_wr_data,
	output logic [ghb_pkg::ADDR_W-1:0]         o_rd_addr,
	input  wire logic [ghb_pkg::DATA_W-1:0]    i_rd_data,
	output logic [7:0]                         o_panel_pixel_data,
	output logic                               o_panel_line_pulse,
	output logic                               o_panel_ac_toggle
);
	import ghb_pkg::*;

	typedef enum logic [1:0] {GHB_IDLE, GHB_WAIT, GHB_HOLD} ghb_st_t;

	// Host reset, read and write pins are asynchronous, so each passes two flip-flops first.
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] next_sync1;
	logic [2:0] next_sync2;
	logic       pin_rst_n;
	logic       ncs_s;
	logic       nrd_s;
	logic       nwr_s;
	ghb_st_t    st;
	ghb_st_t    next_st;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic       is_wr;
	logic       next_is_wr;
	logic       wait_n;
	logic       next_wait_n;
	logic       wait_oe;
	logic       next_wait_oe;
	logic [DATA_W-1:0] rdat;
	logic [DATA_W-1:0] next_rdat;
	logic       rdat_oe;
	logic       next_rdat_oe;
	logic       wr_valid;
	logic       next_wr_valid;
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W-1:0] next_wr_data;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] next_addr_q;
	logic [DATA_W-1:0] data_q;
	logic [DATA_W-1:0] next_data_q;
	logic [7:0] pix;
	logic [7:0] next_pix;
	logic       line_p;
	logic       next_line_p;
	logic       ac;
	logic       next_ac;
	logic       in_rst;
	logic       strobe;

	always_comb begin
		next_sync1 = {bus.nrst, bus.nrd, bus.nwr};
		next_sync2 = sync1;
	end
	// The reset pin bit starts in its asserted state. This keeps the panel
	// and the bus halted while the pin level travels through the pair.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			sync1 <= 3'h3;
			sync2 <= 3'h3;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end
	assign pin_rst_n = sync2[2];
	assign nrd_s     = sync2[1];
	assign nwr_s     = sync2[0];
	// Chip select is only sampled together with a strobe, so it shares
	// its qualifying window; a stale select cannot open an access alone.
	assign ncs_s     = bus.ncs;
	assign in_rst    = !i_nrst || !pin_rst_n;
	assign strobe    = !ncs_s && (!nrd_s || !nwr_s);

	always_comb begin
		next_st       = st;
		next_cnt      = cnt;
		next_is_wr    = is_wr;
		next_wait_n   = wait_n;
		next_wait_oe  = wait_oe;
		next_rdat     = rdat;
		next_rdat_oe  = rdat_oe;
		next_wr_valid = 1'b0;
		next_wr_addr  = wr_addr;
		next_wr_data  = wr_data;
		next_addr_q   = bus.host_addr_bus;
		next_data_q   = bus.hdat_host;
		unique case (st)
			GHB_IDLE: begin
				if (strobe) begin
					next_st      = GHB_WAIT;
					next_cnt     = '0;
					next_is_wr   = !nwr_s;
					next_wait_n  = 1'b0;
					next_wait_oe = i_wait_mode;
					next_rdat_oe = nwr_s;
				end
			end
			GHB_WAIT: begin
				next_cnt = cnt + 1'b1;
				if (!is_wr) begin
					next_rdat = i_rd_data;
				end
				if (cnt == CNT_W'(WAIT_CYC - 1)) begin
					next_st     = GHB_HOLD;
					next_wait_n = 1'b1;
				end
			end
			GHB_HOLD: begin
				if (nrd_s && nwr_s) begin
					next_st      = GHB_IDLE;
					next_wait_oe = 1'b0;
					next_rdat_oe = 1'b0;
					if (is_wr) begin
						next_wr_valid = 1'b1;
						next_wr_addr  = addr_q;
						next_wr_data  = data_q;
					end
				end
			end
			default: next_st = GHB_IDLE;
		endcase
		if (in_rst) begin
			next_st       = GHB_IDLE;
			next_wait_n   = 1'b1;
			next_wait_oe  = 1'b0;
			next_rdat_oe  = 1'b0;
			next_wr_valid = 1'b0;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			st       <= GHB_IDLE;
			cnt      <= '0;
			is_wr    <= 1'b0;
			wait_n   <= 1'b1;
			wait_oe  <= 1'b0;
			rdat     <= '0;
			rdat_oe  <= 1'b0;
			wr_valid <= 1'b0;
			wr_addr  <= '0;
			wr_data  <= '0;
			addr_q   <= '0;
			data_q   <= '0;
		end else begin
			st       <= next_st;
			cnt      <= next_cnt;
			is_wr    <= next_is_wr;
			wait_n   <= next_wait_n;
			wait_oe  <= next_wait_oe;
			rdat     <= next_rdat;
			rdat_oe  <= next_rdat_oe;
			wr_valid <= next_wr_valid;
			wr_addr  <= next_wr_addr;
			wr_data  <= next_wr_data;
			addr_q   <= next_addr_q;
			data_q   <= next_data_q;
		end
	end

	// Small stand-in panel pattern; it only exists to show the halt.
	always_comb begin
		next_pix    = pix + PIX_STEP;
		next_line_p = (pix == LINE_LEN);
		next_ac     = ac ^ (pix == LINE_LEN);
		if (in_rst) begin
			next_pix    = PIX_RESET;
			next_line_p = 1'b0;
			next_ac     = 1'b0;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			pix    <= PIX_RESET;
			line_p <= 1'b0;
			ac     <= 1'b0;
		end else begin
			pix    <= next_pix;
			line_p <= next_line_p;
			ac     <= next_ac;
		end
	end

	assign bus.nwait       = wait_n;
	assign bus.nwait_oe    = wait_oe;
	assign bus.hdat_dev    = rdat;
	assign bus.hdat_dev_oe = rdat_oe;
	assign o_wr_valid      = wr_valid;
	assign o_wr_addr       = wr_addr;
	assign o_wr_data       = wr_data;
	assign o_rd_addr       = addr_q;
	assign o_panel_pixel_data = pix;
	assign o_panel_line_pulse = line_p;
	assign o_panel_ac_toggle  = ac;
endmodule

// *** design/ghb_pkg.sv ***
package ghb_pkg;
	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned ADDR_W         = 16;
	localparam int unsigned DATA_W         = 8;
	// Times in ns; cycle counts derived at 10 ns per system clock period.
	localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
	localparam int unsigned RST_HOLD_NS    = 1000000;
	localparam int unsigned STAB_NS        = 3000000;
	localparam int unsigned RST_HOLD_CYC   =
		(RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STAB_CYC       =
		(STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAIT_MAX_CYC   = 4;
	localparam int unsigned WAIT_CYC       = 3;
	localparam int unsigned RD_DATA_CYC    = 4;
	localparam int unsigned STROBE_MIN_CYC = 5;
	localparam int unsigned IDLE_RD_CYC    = 1;
	localparam int unsigned IDLE_WW_CYC    = 3;
	localparam int unsigned IDLE_WR_CYC    = 6;
	localparam int unsigned CNT_W          = 8;
	localparam int unsigned STAB_W         = 32;
	localparam logic [7:0]  PIX_RESET      = 8'h00;
	localparam logic [7:0]  PIX_STEP       = 8'h01;
	localparam logic [7:0]  LINE_LEN       = 8'h3F;
endpackage

// *** design/ghb_if.sv ***
interface ghb_if;
	import ghb_pkg::*;
	logic              nrst;
	logic              ncs;
	logic              nrd;
	logic              nwr;
	logic [ADDR_W-1:0] host_addr_bus;
	logic [DATA_W-1:0] hdat_host;
	logic              hdat_host_oe;
	logic [DATA_W-1:0] hdat_dev;
	logic              hdat_dev_oe;
	logic              nwait;
	logic              nwait_oe;
	logic [DATA_W-1:0] host_data_bus;
	logic              wait_line_n;
	assign host_data_bus = hdat_host_oe ? hdat_host :
		(hdat_dev_oe ? hdat_dev : '0);
	assign wait_line_n = nwait_oe ? nwait : 1'b1;
	modport dev (input nrst, ncs, nrd, nwr, host_addr_bus, hdat_host,
		output hdat_dev, hdat_dev_oe, nwait, nwait_oe);
	modport host (output nrst, ncs, nrd, nwr, host_addr_bus, hdat_host,
		hdat_host_oe, input hdat_dev, wait_line_n);
endinterface

// *** design/ghb_host.sv ***
module ghb_host #(
	parameter int unsigned RST_CYC  = ghb_pkg::RST_HOLD_CYC,
	parameter int unsigned STAB_CYCP = ghb_pkg::STAB_CYC
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_nrst,
	input  wire logic                       i_wait_mode,
	ghb_if.host                             bus,
	input  wire logic                       i_req,
	input  wire logic                       i_req_wr,
	input  wire logic [ghb_pkg::ADDR_W-1:0] i_req_addr,
	input  wire logic [ghb_pkg::DATA_W-1:0] i_req_data,
	output logic                            o_ready,
	output logic                            o_done,
	output logic [ghb_pkg::DATA_W-1:0]      o_rd_data
);
	import ghb_pkg::*;

	typedef enum logic [2:0] {
		GHH_RST, GHH_STAB, GHH_IDLE, GHH_ACT, GHH_GAP
	} ghh_st_t;

	logic [1:0]  wsync;
	logic [1:0]  next_wsync;
	ghh_st_t     st;
	ghh_st_t     next_st;
	logic [STAB_W-1:0] cnt;
	logic [STAB_W-1:0] next_cnt;
	logic        wr;
	logic        next_wr;
	logic        last_wr;
	logic        next_last_wr;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] data;
	logic [DATA_W-1:0] next_data;
	logic        nrst_pin;
	logic        next_nrst_pin;
	logic        strobe_n;
	logic        next_strobe_n;
	logic        ready;
	logic        next_ready;
	logic        done;
	logic        next_done;
	logic [DATA_W-1:0] rdat;
	logic [DATA_W-1:0] next_rdat;

	always_comb begin
		next_wsync = {wsync[0], bus.wait_line_n};
	end

	always_comb begin
		next_st       = st;
		next_cnt      = cnt + 1'b1;
		next_wr       = wr;
		next_last_wr  = last_wr;
		next_addr     = addr;
		next_data     = data;
		next_nrst_pin = nrst_pin;
		next_strobe_n = strobe_n;
		next_ready    = 1'b0;
		next_done     = 1'b0;
		next_rdat     = rdat;
		unique case (st)
			GHH_RST: begin
				if (cnt >= STAB_W'(RST_CYC)) begin
					next_st       = GHH_STAB;
					next_cnt      = '0;
					next_nrst_pin = 1'b1;
				end
			end
			GHH_STAB: begin
				if (cnt >= STAB_W'(STAB_CYCP)) begin
					next_st    = GHH_IDLE;
					next_ready = 1'b1;
				end
			end
			GHH_IDLE: begin
				next_ready = 1'b1;
				if (i_req) begin
					next_st       = GHH_ACT;
					next_ready    = 1'b0;
					next_cnt      = '0;
					next_wr       = i_req_wr;
					next_addr     = i_req_addr;
					next_data     = i_req_data;
					next_strobe_n = 1'b0;
				end
			end
			GHH_ACT: begin
				// In wait mode the strobe ends once wait has gone high and the minimum width has passed;
				// without it, after the fixed minimum width.
				if ((i_wait_mode && cnt >= STAB_W'(STROBE_MIN_CYC)
					&& wsync[1]) || (!i_wait_mode
					&& cnt >= STAB_W'(STROBE_MIN_CYC))) begin
					next_st       = GHH_GAP;
					next_strobe_n = 1'b1;
					next_cnt      = '0;
					next_last_wr  = wr;
					next_done     = 1'b1;
					next_rdat     = bus.hdat_dev;
				end
			end
			GHH_GAP: begin
				// Longest gap covers a write then read
				if (cnt >= STAB_W'(IDLE_WR_CYC) || (!last_wr
					&& cnt >= STAB_W'(IDLE_RD_CYC))) begin
					next_st    = GHH_IDLE;
					next_ready = 1'b1;
				end
			end
			default: next_st = GHH_RST;
		endcase
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			wsync    <= 2'h3;
			st       <= GHH_RST;
			cnt      <= '0;
			wr       <= 1'b0;
			last_wr  <= 1'b0;
			addr     <= '0;
			data     <= '0;
			nrst_pin <= 1'b0;
			strobe_n <= 1'b1;
			ready    <= 1'b0;
			done     <= 1'b0;
			rdat     <= '0;
		end else begin
			wsync    <= next_wsync;
			st       <= next_st;
			cnt      <= next_cnt;
			wr       <= next_wr;
			last_wr  <= next_last_wr;
			addr     <= next_addr;
			data     <= next_data;
			nrst_pin <= next_nrst_pin;
			strobe_n <= next_strobe_n;
			ready    <= next_ready;
			done     <= next_done;
			rdat     <= next_rdat;
		end
	end

	assign bus.nrst          = nrst_pin;
	assign bus.ncs           = strobe_n;
	assign bus.nrd           = strobe_n | wr;
	assign bus.nwr           = strobe_n | !wr;
	assign bus.host_addr_bus = addr;
	assign bus.hdat_host     = data;
	assign bus.hdat_host_oe  = wr;
	assign o_ready   = ready;
	assign o_done    = done;
	assign o_rd_data = rdat;
endmodule

// *** verif/ghb_checker.sv ***
module ghb_checker (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_wait_mode,
	input wire logic nrst,
	input wire logic ncs,
	input wire logic nrd,
	input wire logic nwr,
	input wire logic nwait,
	input wire logic nwait_oe,
	input wire logic hdat_dev_oe,
	input wire logic wait_line_n
);
	logic strb_n;
	logic wact;
	assign strb_n = nrd & nwr;
	assign wact = nwait_oe & ~nwait;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	AST_WAIT_LOW: assert property (
		$fell(strb_n) && !ncs && i_wait_mode |-> ##[1:4] wact)
		else $error("wait not driven low");
	AST_WAIT_MAX: assert property ($rose(wact) |-> ##[1:4] !wact)
		else $error("wait held too long");
	AST_WAIT_REL: assert property ($rose(strb_n) |-> ##[1:4] !nwait_oe)
		else $error("wait not released");
	AST_IDLE_FREE: assert property (
		(strb_n)[*6] |-> !nwait_oe && !hdat_dev_oe)
		else $error("bus driven while idle");
	AST_RST_QUIET: assert property (
		(!nrst)[*3] |-> !nwait_oe && !hdat_dev_oe)
		else $error("bus driven in reset");
	AST_RD_DRIVE: assert property (
		$fell(nrd) && !ncs |-> ##[1:4] hdat_dev_oe)
		else $error("read data late");
	AST_RD_AT_WAIT: assert property (
		$rose(wait_line_n) && !nrd |-> hdat_dev_oe)
		else $error("no data at wait end");
	AST_CS_QUAL: assert property (
		(ncs)[*6] |-> !hdat_dev_oe && !nwait_oe)
		else $error("drive without select");
	AST_WR_NODRV: assert property ((!nwr)[*3] |-> !hdat_dev_oe)
		else $error("data driven in write");
	cover property ($fell(nwr) && !ncs);
	cover property ($fell(nrd) && !ncs && i_wait_mode);
	cover property ($fell(nrd) && !ncs && !i_wait_mode);
endmodule

// *** verif/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ghb_pkg::*;
	logic              clk;
	logic              rst_n;
	logic              wmode;
	logic              req;
	logic              req_wr;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_data;
	logic              ready;
	logic              done;
	logic [DATA_W-1:0] rd_data;
	logic              wr_valid;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_src;
	logic [7:0]        pix;
	logic              lp;
	logic              act;
	int                error_cnt = 0;
	int                n_tests = 0;
	int                wlow = 0;
	ghb_if bus_if();
	// Read source depends on the address so a stale byte cannot match.
	assign rd_src = rd_addr[7:0] ^ 8'h5A;
	ghb_host #(
		.RST_CYC   (20),
		.STAB_CYCP (50)
	) ghb_host_inst (
		.i_sys_clk  (clk),
		.i_nrst     (rst_n),
		.i_wait_mode(wmode),
		.bus        (bus_if),
		.i_req      (req),
		.i_req_wr   (req_wr),
		.i_req_addr (req_addr),
		.i_req_data (req_data),
		.o_ready    (ready),
		.o_done     (done),
		.o_rd_data  (rd_data)
	);
	ghb_device ghb_device_inst (
		.i_sys_clk         (clk),
		.i_nrst            (rst_n),
		.i_wait_mode       (wmode),
		.bus               (bus_if),
		.o_wr_valid        (wr_valid),
		.o_wr_addr         (wr_addr),
		.o_wr_data         (wr_data),
		.o_rd_addr         (rd_addr),
		.i_rd_data         (rd_src),
		.o_panel_pixel_data(pix),
		.o_panel_line_pulse(lp),
		.o_panel_ac_toggle (act)
	);
	ghb_checker ghb_checker_inst (
		.i_sys_clk  (clk),
		.i_nrst     (rst_n),
		.i_wait_mode(wmode),
		.nrst       (bus_if.nrst),
		.ncs        (bus_if.ncs),
		.nrd        (bus_if.nrd),
		.nwr        (bus_if.nwr),
		.nwait      (bus_if.nwait),
		.nwait_oe   (bus_if.nwait_oe),
		.hdat_dev_oe(bus_if.hdat_dev_oe),
		.wait_line_n(bus_if.wait_line_n)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) begin
		if (bus_if.wait_line_n === 1'b0) wlow++;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Every wait is bounded so a stuck handshake ends the run.
	task automatic wfor(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 100) begin
				error_cnt++;
				end_sim();
			end
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		wfor(ready);
		req = 1'b1;
		req_wr = w;
		req_addr = a;
		req_data = d;
		@(negedge clk);
		req = 1'b0;
		wfor(done);
		if (w) begin
			wfor(wr_valid);
			chk(wr_addr, a);
			chk(16'(wr_data), 16'(d));
		end else begin
			chk(16'(rd_data), 16'(a[7:0] ^ 8'h5A));
		end
	endtask
	task automatic t_reset();
		int n;
		@(negedge clk);
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(16'(bus_if.nrst), 16'h0000);
		chk(16'(pix), 16'h0000);
		chk(16'(lp), 16'h0000);
		chk(16'(act), 16'h0000);
		n = 10;
		while (ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n >= 70 && n < 200), 16'h0001);
		if (ready !== 1'b1) begin
			end_sim();
		end
		$display("reset test done");
	endtask
	task automatic t_wait();
		int w0;
		wmode = 1'b1;
		w0 = wlow;
		acc(1'b1, 16'h1234, 8'hA5);
		acc(1'b1, 16'hFFFF, 8'h5A);
		acc(1'b0, 16'h00C3, 8'h00);
		acc(1'b1, 16'h0000, 8'hFF);
		acc(1'b0, 16'h7F3C, 8'h00);
		chk(16'(wlow > w0), 16'h0001);
		$display("wait mode test done");
	endtask
	task automatic t_nowait();
		int w0;
		wmode = 1'b0;
		w0 = wlow;
		acc(1'b1, 16'h8001, 8'h3C);
		acc(1'b0, 16'h80FE, 8'h00);
		chk(16'(wlow - w0), 16'h0000);
		$display("no wait test done");
	endtask
	initial begin
		rst_n = 1'b0;
		wmode = 1'b1;
		req = 1'b0;
		req_wr = 1'b0;
		req_addr = '0;
		req_data = '0;
		t_reset();
		t_wait();
		t_nowait();
		// A second reset in mid-run must halt the panel again.
		t_reset();
		t_wait();
		end_sim();
	end
endmodule
